// ==== dv/tmr_src.sv ====
// partner model: gate and external clock sources of the three channels
// assumes ref_clk from the bench; levels change just after rising edges
module tmr_src (
  // clock
  input wire logic ref_clk,
  // channel pins
  output logic [2:0] gate_n,
  output logic [2:0] ext_clk_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************
  // gate cycles
  // ************************************************
  // external clocks stand still: a channel counts only while its control bit1 selects the internal clock
  initial begin
    gate_n = 3'h7;
    ext_clk_n = 3'h7;
  end
  // one gate cycle: low for lo clocks, then high for hi clocks
  task automatic pulse(input int ch, input int lo, input int hi);
    @(posedge ref_clk);
    gate_n[ch] <= 1'b0;
    repeat (lo) @(posedge ref_clk);
    gate_n[ch] <= 1'b1;
    repeat (hi) @(posedge ref_clk);
  endtask
endmodule

// ==== dv/tmr_top_tb.sv ====
// self-checking bench of the timer: apb master, gate source, scenarios
// assumes tmr_top with pready from the design, gate_n synchronous
module tmr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tmr_pkg::*;
  // ************************************************
  // harness
  // ************************************************
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, c0;
  logic [2:0] gate_n, ext_clk_n, pin;
  int n_fail, cmp_count, cyc;
  tmr_top dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gate_n(gate_n), .ext_clk_n(ext_clk_n),
    .channel_output_pin(pin), .irq(irq));
  tmr_src src (.ref_clk(ref_clk), .gate_n(gate_n), .ext_clk_n(ext_clk_n));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one transfer, entered just after an edge; an idle edge follows it
  task automatic apb(input int w, input logic [7:0] a, input int d);
    psel <= 1'b1;
    pwrite <= (w != 0);
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic st(input int ch, input logic exp);
    apb(0, TMR_ADDR_STATUS, 0);
    chk(rd[ch], exp);
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_regs;
    apb(0, TMR_ADDR_CTRL1, 0);
    chk(rd, 32'h01);
    apb(0, TMR_ADDR_COUNT1, 0);
    chk(rd, 32'hffff);
    apb(0, 8'h28, 0);
    chk({rd[30:0], err}, 32'h01);
    // steering bit clear: the shared offset lands in ctrl3
    apb(1, TMR_ADDR_CTRL1, 32'h04);
    apb(0, TMR_ADDR_CTRL3, 0);
    chk(rd, 32'h04);
    apb(0, TMR_ADDR_CTRL1, 0);
    chk(rd, 32'h01);
    apb(1, TMR_ADDR_CTRL2, 32'h01);
    apb(1, TMR_ADDR_CTRL1, 32'h00);
    apb(0, TMR_ADDR_CTRL1, 0);
    chk(rd, 32'h00);
    apb(0, TMR_ADDR_CTRL3, 0);
    chk(rd, 32'h04);
  endtask
  // gate held high all along: counting must not wait for it
  task automatic t_shot;
    apb(1, TMR_ADDR_CTRL1, 32'he2);
    apb(1, TMR_ADDR_LATCH1, 32'h08);
    repeat (12) @(posedge ref_clk);
    st(0, 1'b1);
    chk(pin[0], 1'b0);
    chk(irq, 1'b1);
    apb(1, TMR_ADDR_STATUS, 32'h01);
    repeat (12) @(posedge ref_clk);
    st(0, 1'b1);
    chk(pin[0], 1'b0);
    apb(1, TMR_ADDR_CTRL1, 32'ha2);
    chk(irq, 1'b0);
    apb(1, TMR_ADDR_LATCH1, 32'h08);
    st(0, 1'b0);
    chk(pin[0], 1'b1);
  endtask
  task automatic t_zero;
    apb(1, TMR_ADDR_LATCH1, 32'h00);
    apb(1, TMR_ADDR_STATUS, 32'h01);
    st(0, 1'b1);
    chk(pin[0], 1'b0);
    apb(0, TMR_ADDR_COUNT1, 0);
    chk(rd, 32'h0);
  endtask
  // period longer than expiry is flagged, shorter ones restart
  task automatic t_long;
    apb(1, TMR_ADDR_CTRL2, 32'heb);
    apb(1, TMR_ADDR_LATCH2, 32'd20);
    apb(1, TMR_ADDR_STATUS, 32'h02);
    repeat (4) src.pulse(1, 3, 7);
    st(1, 1'b0);
    chk(pin[1], 1'b0);
    repeat (30) @(posedge ref_clk);
    st(1, 1'b1);
    chk(pin[1], 1'b1);
    apb(0, TMR_ADDR_COUNT2, 0);
    c0 = rd;
    repeat (5) @(posedge ref_clk);
    apb(0, TMR_ADDR_COUNT2, 0);
    chk(rd, c0);
  endtask
  task automatic t_short;
    apb(1, TMR_ADDR_CTRL2, 32'hcb);
    apb(1, TMR_ADDR_STATUS, 32'h02);
    repeat (2) src.pulse(1, 3, 7);
    st(1, 1'b1);
    apb(1, TMR_ADDR_STATUS, 32'h02);
    // expiry first: blocked, and the next fall restarts quietly
    repeat (2) src.pulse(1, 3, 40);
    st(1, 1'b0);
  endtask
  task automatic t_pulse;
    apb(1, TMR_ADDR_CTRL2, 32'h5b);
    apb(1, TMR_ADDR_STATUS, 32'h02);
    src.pulse(1, 5, 5);
    st(1, 1'b1);
    apb(0, TMR_ADDR_COUNT2, 0);
    c0 = rd;
    repeat (5) @(posedge ref_clk);
    apb(0, TMR_ADDR_COUNT2, 0);
    chk(rd, c0);
    apb(1, TMR_ADDR_CTRL2, 32'h7b);
    apb(1, TMR_ADDR_STATUS, 32'h02);
    src.pulse(1, 5, 5);
    st(1, 1'b0);
    src.pulse(1, 30, 5);
    st(1, 1'b1);
  endtask
  // dual-8 single shot on channel 3: upper byte steps once per lower wrap
  task automatic t_dual;
    apb(1, TMR_ADDR_CTRL2, 32'h00);
    apb(1, TMR_ADDR_CTRL3, 32'ha6);
    apb(1, TMR_ADDR_LATCH3, 32'h0203);
    apb(0, TMR_ADDR_COUNT3, 0);
    chk(rd, 32'h0201);
    apb(0, TMR_ADDR_COUNT3, 0);
    chk(rd, 32'h0102);
    chk(pin[2], 1'b1);
    repeat (6) @(posedge ref_clk);
    st(2, 1'b1);
  endtask
  // ************************************************
  // main sequence and watchdog
  // ************************************************
  initial begin
    cyc = 0;
    forever begin
      @(posedge ref_clk);
      cyc++;
      if (cyc == 20000) begin
        n_fail++;
        wrap_up();
      end
    end
  end
  initial begin
    n_fail = 0;
    cmp_count = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_shot();
    t_zero();
    t_long();
    t_short();
    t_pulse();
    t_dual();
    wrap_up();
  end
endmodule

// ==== hw/tmr_chan.sv ====
// one timer channel: counter, flag, enable flip-flop and output
// assumes gate/clock inputs already synchronous to ref_clk
//
// Our own choices: the register offsets and the APB interface to the registers.
module tmr_chan
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // control
  input wire logic [7:0] ctrl,
  input wire logic [15:0] latch,
  input wire logic latch_wr,
  input wire logic preset,
  input wire logic flag_clr,
  input wire logic cnt_tick,
  // gate
  input wire logic gate_n,
  // results
  output logic [15:0] count,
  output logic flag,
  output logic wave
);
  import tmr_pkg::*;
  logic [15:0] cnt_r, cnt_nxt;
  logic flag_r, flag_nxt, wave_r, wave_nxt, ce_r, ce_nxt;
  logic first_r, first_nxt, blk_r, blk_nxt, gate_q_r;
  logic gfall, grise, expire, init, run, zero;
  tmr_mode_t mode;

  // ************************************************
  // mode decode
  // ************************************************
  always_comb begin
    mode = TMR_M_CONT;
    if (!ctrl[TMR_B_MEAS] && ctrl[TMR_B_SENSE])
      mode = TMR_M_SHOT; // RULE_05
    else if (ctrl[TMR_B_MEAS] && ctrl[TMR_B_KIND])
      mode = TMR_M_PULSE; // RULE_08
    else if (ctrl[TMR_B_MEAS])
      mode = TMR_M_FREQ; // RULE_08
  end

  assign gfall = gate_q_r & ~gate_n;
  assign grise = ~gate_q_r & gate_n;
  assign zero = (latch == 16'h0000);

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    cnt_nxt = cnt_r;
    flag_nxt = flag_r & ~flag_clr;
    wave_nxt = wave_r;
    ce_nxt = ce_r;
    first_nxt = first_r;
    blk_nxt = blk_r;
    init = preset;
    run = 1'b1;
    case (mode)
      TMR_M_CONT: begin
        init = preset | gfall | (latch_wr & ~ctrl[TMR_B_KIND]);
        run = ~gate_n;
      end
      TMR_M_SHOT: begin
        init = preset | gfall | (latch_wr & ~ctrl[TMR_B_KIND]); // RULE_05
        run = 1'b1; // RULE_03
      end
      TMR_M_FREQ: begin
        run = ce_r; // RULE_12
        if (ctrl[TMR_B_SENSE])
          init = preset | (gfall & ~flag_r); // RULE_09 RULE_13
        else
          init = preset | (gfall & ~flag_r & (~ce_r | blk_r)); // RULE_10
      end
      TMR_M_PULSE: begin
        run = ce_r & ~gate_n; // RULE_15
        init = preset | (gfall & ~flag_r); // RULE_14
      end
      default: begin
        init = preset;
        run = 1'b0;
      end
    endcase
    // dual-8 expiry: both bytes zero; 16-bit: whole word zero
    expire = cnt_tick & run & (cnt_r == 16'h0000); // RULE_07
    // enable flip-flop of the measurement modes
    if (latch_wr | preset | flag_r)
      ce_nxt = 1'b0; // RULE_11
    else if (gfall)
      ce_nxt = 1'b1; // RULE_11
    if (mode == TMR_M_PULSE && gate_n)
      ce_nxt = 1'b0; // RULE_15
    if (expire) begin
      // reload on expiry; flag and output depend on mode
      cnt_nxt = latch; // RULE_02
      wave_nxt = first_r ? 1'b1 : ~wave_r; // RULE_06
      first_nxt = 1'b0;
      case (mode)
        TMR_M_SHOT: begin
          flag_nxt = 1'b1; // RULE_02
          wave_nxt = 1'b0; // RULE_01
        end
        TMR_M_FREQ: begin
          if (ctrl[TMR_B_SENSE]) begin
            flag_nxt = 1'b1; // RULE_09
            ce_nxt = 1'b0; // RULE_09
          end else
            blk_nxt = 1'b1; // RULE_10
        end
        TMR_M_PULSE: begin
          if (ctrl[TMR_B_SENSE]) begin
            flag_nxt = 1'b1; // RULE_14
            ce_nxt = 1'b0;
          end
        end
        default: flag_nxt = 1'b1;
      endcase
    end else if (cnt_tick & run) begin
      if (ctrl[TMR_B_DUAL] && cnt_r[7:0] == 8'h00)
        cnt_nxt = {cnt_r[15:8] - 8'h01, latch[7:0]}; // RULE_18
      else if (ctrl[TMR_B_DUAL])
        cnt_nxt = {cnt_r[15:8], cnt_r[7:0] - 8'h01};
      else
        cnt_nxt = cnt_r - 16'h0001;
    end
    // gate edges that decide measurement flags
    if (mode == TMR_M_FREQ && !ctrl[TMR_B_SENSE] && gfall && ce_r && !blk_r && !expire)
      flag_nxt = 1'b1; // RULE_10
    if (mode == TMR_M_PULSE && !ctrl[TMR_B_SENSE] && grise && ce_r && !expire)
      flag_nxt = 1'b1; // RULE_14
    // counter initialization overrides
    if (init) begin
      cnt_nxt = latch; // RULE_17
      flag_nxt = 1'b0; // RULE_17
      // single-shot pulse starts at init, other modes start low
      wave_nxt = (mode == TMR_M_SHOT) & ~zero; // RULE_01 RULE_06
      first_nxt = 1'b1;
      blk_nxt = 1'b0;
      if (mode == TMR_M_FREQ || mode == TMR_M_PULSE)
        ce_nxt = ~preset & ~latch_wr;
    end
    if (mode == TMR_M_SHOT && zero)
      wave_nxt = 1'b0; // RULE_04
    // a hardware set beats a simultaneous software clear
    if (flag_r && !flag_clr && !init)
      flag_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= TMR_LATCH_RST;
      flag_r <= 1'b0;
      wave_r <= 1'b0;
      ce_r <= 1'b0;
      first_r <= 1'b1;
      blk_r <= 1'b0;
      gate_q_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      flag_r <= flag_nxt;
      wave_r <= wave_nxt;
      ce_r <= ce_nxt;
      first_r <= first_nxt;
      blk_r <= blk_nxt;
      gate_q_r <= gate_n;
    end
  end

  assign count = cnt_r;
  assign flag = flag_r;
  assign wave = wave_r;

  // ************************************************
  // checks
  // ************************************************
  a_init_clears_flag: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_17
    init |=> (!flag_r && cnt_r == $past(latch)))
    else $error("init did not load latch or clear flag");
  a_shot_expiry_flag: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_02
    (mode == TMR_M_SHOT && expire && !init) |=> flag_r)
    else $error("single-shot expiry did not set flag");
  a_shot_low_after: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_01
    (mode == TMR_M_SHOT && expire && !init) |=> !wave_r)
    else $error("single-shot output high after expiry");
  a_shot_init_high: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_01
    (mode == TMR_M_SHOT && init && !zero) |=> wave_r)
    else $error("single-shot output not high after init");
  a_shot_zero_low: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_04
    (mode == TMR_M_SHOT && zero) |=> !wave_r)
    else $error("zero latch single-shot output not low");
  a_meas_first_high: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_06
    (mode == TMR_M_FREQ && expire && first_r && !init) |=> wave_r)
    else $error("measure output not high at first expiry");
  a_freq_long_stop: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_09
    (mode == TMR_M_FREQ && ctrl[TMR_B_SENSE] && expire && !init) |=> (flag_r && !ce_r))
    else $error("period long expiry did not flag and stop");
  a_ce_cleared: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_11
    (ctrl[TMR_B_MEAS] && (latch_wr || preset)) |=> !ce_r)
    else $error("enable flip-flop not cleared");
  a_pulse_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_15
    (mode == TMR_M_PULSE && gate_n && !init && $stable(gate_n)) |=> $stable(cnt_r))
    else $error("pulse width count moved with gate high");
endmodule

// ==== hw/tmr_pkg.sv ====
// constants, register map and mode codes of the three-channel timer
// assumes an apb master on ref_clk and synchronous gate/clock inputs
//
// Function
// RULE_01: single-shot output low after first expiry
// RULE_02: single-shot expiry sets flag and reloads
// RULE_03: single-shot counting ignores gate level
// RULE_04: zero latch single-shot keeps output low
// RULE_05: single-shot select and init sources by bit4 (the code selects single-shot by bit5 with bit3 clear)
// RULE_06: measure output low, high, then toggles
// RULE_07: measure modes keep 16 or dual-8 counting
// RULE_08: bits 4,5 pick measure flag condition
// RULE_09: period long: expiry first flags and stops
// RULE_10: period short: early edge flags, else blocked
// RULE_11: gate fall sets enable; write/reset/flag clear
// RULE_12: period mode counts until flag, write, reset
// RULE_13: period long: early gate edge restarts
// RULE_14: pulse width ends at gate rise
// RULE_15: pulse width stops on high gate or flag
// RULE_16: bit0 meanings of the three control registers
// RULE_17: initialization loads latches and clears flag
// RULE_18: dual-8 upper byte steps per lower wrap
// RULE_19: counting identical regardless of output enable
// RULE_20: control bit1 selects internal or external clock
// RULE_21: bit6 unmasks flag to irq, bit7 drives pin
package tmr_pkg;
  // ************************************************
  // register map (byte addresses)
  // ************************************************
  localparam logic [7:0] TMR_ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] TMR_ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] TMR_ADDR_CTRL3 = 8'h08;
  localparam logic [7:0] TMR_ADDR_LATCH1 = 8'h0c;
  localparam logic [7:0] TMR_ADDR_LATCH2 = 8'h10;
  localparam logic [7:0] TMR_ADDR_LATCH3 = 8'h14;
  localparam logic [7:0] TMR_ADDR_STATUS = 8'h18;
  localparam logic [7:0] TMR_ADDR_COUNT1 = 8'h1c;
  localparam logic [7:0] TMR_ADDR_COUNT2 = 8'h20;
  localparam logic [7:0] TMR_ADDR_COUNT3 = 8'h24;
  // ************************************************
  // control field positions
  // ************************************************
  localparam int TMR_B_LOW = 0;
  localparam int TMR_B_CLKSEL = 1;
  localparam int TMR_B_DUAL = 2;
  localparam int TMR_B_MEAS = 3;
  localparam int TMR_B_KIND = 4;
  localparam int TMR_B_SENSE = 5;
  localparam int TMR_B_IRQEN = 6;
  localparam int TMR_B_OEN = 7;
  // ************************************************
  // reset values
  // ************************************************
  localparam logic [7:0] TMR_CTRL1_RST = 8'h01;
  localparam logic [7:0] TMR_CTRL_RST = 8'h00;
  localparam logic [15:0] TMR_LATCH_RST = 16'hffff;
  localparam logic [2:0] TMR_PRESC_MAX = 3'h7;
  typedef enum logic [3:0] {
    TMR_M_CONT = 4'h1,
    TMR_M_SHOT = 4'h2,
    TMR_M_FREQ = 4'h4,
    TMR_M_PULSE = 4'h8
  } tmr_mode_t;
endpackage

// ==== hw/tmr_top.sv ====
// apb slave with three timer channels and shared interrupt
// assumes a single ref_clk domain and synchronous gate/clock inputs
module tmr_top
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel pins
  input wire logic [2:0] gate_n,
  input wire logic [2:0] ext_clk_n,
  output logic [2:0] channel_output_pin,
  output logic irq
);
  import tmr_pkg::*;
  logic [7:0] ctrl_r [3];
  logic [7:0] ctrl_nxt [3];
  logic [15:0] latch_r [3];
  logic [15:0] latch_nxt [3];
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0] presc_r, presc_nxt, eclk_q_r, lwr, fclr, tick, flag, wave;
  logic [15:0] count [3];
  logic wr, rd, hit, err_r, err_nxt;

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;

  // ************************************************
  // register writes
  // ************************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    latch_nxt = latch_r;
    lwr = 3'b000;
    fclr = 3'b000;
    presc_nxt = presc_r + 3'h1;
    if (wr) begin
      case (paddr)
        TMR_ADDR_CTRL1, TMR_ADDR_CTRL3: begin
          // writes to either the ctrl1 or the ctrl3 offset, steered by ctrl2 bit0
          if (ctrl_r[1][TMR_B_LOW])
            ctrl_nxt[0] = pwdata[7:0]; // RULE_16
          else
            ctrl_nxt[2] = pwdata[7:0]; // RULE_16
        end
        TMR_ADDR_CTRL2: ctrl_nxt[1] = pwdata[7:0];
        TMR_ADDR_LATCH1: begin
          latch_nxt[0] = pwdata[15:0];
          lwr[0] = 1'b1;
        end
        TMR_ADDR_LATCH2: begin
          latch_nxt[1] = pwdata[15:0];
          lwr[1] = 1'b1;
        end
        TMR_ADDR_LATCH3: begin
          latch_nxt[2] = pwdata[15:0];
          lwr[2] = 1'b1;
        end
        TMR_ADDR_STATUS: fclr = pwdata[2:0];
        default: ;
      endcase
    end
  end

  // ************************************************
  // read mux and apb answer
  // ************************************************
  always_comb begin
    hit = 1'b1;
    case (paddr)
      TMR_ADDR_CTRL1: rdata_nxt = {24'h000000, ctrl_r[0]};
      TMR_ADDR_CTRL2: rdata_nxt = {24'h000000, ctrl_r[1]};
      TMR_ADDR_CTRL3: rdata_nxt = {24'h000000, ctrl_r[2]};
      TMR_ADDR_LATCH1: rdata_nxt = {16'h0000, latch_r[0]};
      TMR_ADDR_LATCH2: rdata_nxt = {16'h0000, latch_r[1]};
      TMR_ADDR_LATCH3: rdata_nxt = {16'h0000, latch_r[2]};
      TMR_ADDR_STATUS: rdata_nxt = {29'h00000000, flag};
      TMR_ADDR_COUNT1: rdata_nxt = {16'h0000, count[0]};
      TMR_ADDR_COUNT2: rdata_nxt = {16'h0000, count[1]};
      TMR_ADDR_COUNT3: rdata_nxt = {16'h0000, count[2]};
      default: begin
        rdata_nxt = 32'h00000000;
        hit = 1'b0;
      end
    endcase
    if (!rd)
      rdata_nxt = rdata_r;
    err_nxt = psel & ~penable & ~hit;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r[0] <= TMR_CTRL1_RST;
      ctrl_r[1] <= TMR_CTRL_RST;
      ctrl_r[2] <= TMR_CTRL_RST;
      latch_r[0] <= TMR_LATCH_RST;
      latch_r[1] <= TMR_LATCH_RST;
      latch_r[2] <= TMR_LATCH_RST;
      rdata_r <= 32'h00000000;
      presc_r <= 3'h0;
      eclk_q_r <= 3'h7;
      err_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      latch_r <= latch_nxt;
      rdata_r <= rdata_nxt;
      presc_r <= presc_nxt;
      eclk_q_r <= ext_clk_n;
      err_r <= err_nxt;
    end
  end

  // read data driven straight from the read mux during the access phase, ready at the access edge
  assign prdata = (rd && hit) ? rdata_nxt : 32'h00000000;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_r;

  // ************************************************
  // channels
  // ************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_ch
      logic int_tick;
      // timer 3 may divide the internal clock by eight
      assign int_tick = (g == 2 && ctrl_r[2][TMR_B_LOW]) ?
        (presc_r == TMR_PRESC_MAX) : 1'b1; // RULE_16
      assign tick[g] = ctrl_r[g][TMR_B_CLKSEL] ? int_tick :
        (eclk_q_r[g] & ~ext_clk_n[g]); // RULE_20
      tmr_chan u_chan (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ctrl(ctrl_r[g]),
        .latch(latch_nxt[g]),
        .latch_wr(lwr[g]),
        .preset(ctrl_r[0][TMR_B_LOW]), // RULE_16
        .flag_clr(fclr[g]),
        .cnt_tick(tick[g]),
        .gate_n(gate_n[g]),
        .count(count[g]),
        .flag(flag[g]),
        .wave(wave[g])
      );
      // pin drive only; counting is untouched by this bit
      assign channel_output_pin[g] = wave[g] & ctrl_r[g][TMR_B_OEN]; // RULE_21 RULE_19
    end
  endgenerate

  assign irq = |(flag & {ctrl_r[2][TMR_B_IRQEN], ctrl_r[1][TMR_B_IRQEN],
    ctrl_r[0][TMR_B_IRQEN]}); // RULE_21

  a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rstn) // RULE_21
    (!ctrl_r[0][TMR_B_IRQEN] && !ctrl_r[1][TMR_B_IRQEN] && !ctrl_r[2][TMR_B_IRQEN])
    |-> !irq)
    else $error("irq raised while all masked");
endmodule
